// >>> dv/apb_host_model.sv
// Purpose: APB host that issues single read and write transfers.
// Assumes: Signals change only right after rising edges of clk_i.
// Notes: A transfer waits for pready_i; only the bench watchdog ends a hung wait.
`timescale 1ns/1ps
module apb_host_model (
  input wire logic clk_i, // Bus clock
  input wire logic [31:0] prdata_i, // Read data
  input wire logic pready_i, // Slave ready
  input wire logic pslverr_i, // Slave error
  output logic psel_o, // Select
  output logic penable_o, // Enable
  output logic pwrite_o, // Direction
  output logic [7:0] paddr_o, // Byte address
  output logic [31:0] pwdata_o // Write data
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h00000000;
  end
  // ==========
  // The request is held until pready_i is sampled high, then released.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// >>> dv/polyphase_energy_accumulator_test.sv
// Purpose: Self-checking bench of the energy accumulator.
// Assumes: Frames arrive every 8 clocks; all phases share one sample set.
// Notes: Energy checks judge growth and sign of accumulators, not size.
`timescale 1ns/1ps
`include "energy_params.svh"
module polyphase_energy_accumulator_test;
  import energy_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic tick = 1'b0;
  logic [2:0] fc = 3'h0;
  logic [2:0] zc = 3'h0;
  logic signed [15:0] sv = 16'sh4000;
  logic signed [15:0] si = 16'sh4000;
  logic signed [15:0] sq = 16'sh4000;
  logic [15:0] irms = 16'h0100;
  logic psel, penable, pwrite, pready, pslverr, irq_n, pulse_en;
  logic [7:0] paddr;
  word_t pwdata, prdata;
  int n_mismatch = 0;
  int cmp_count = 0;
  // ==========
  // Clock, frames, design and host.
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    fc <= fc + 3'h1;
    tick <= (fc == 3'h7);
  end
  polyphase_energy_accumulator dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .frame_tick_i(tick), .v_a_i(sv), .v_b_i(sv), .v_c_i(sv),
    .i_a_i(si), .i_b_i(si), .i_c_i(si), .q_a_i(sq), .q_b_i(sq), .q_c_i(sq), .zc_a_i(zc[0]),
    .zc_b_i(zc[1]), .zc_c_i(zc[2]), .irms_a_i(irms), .irms_b_i(irms), .irms_c_i(irms),
    .vrms_a_i(irms), .vrms_b_i(irms), .vrms_c_i(irms), .irq_n_o(irq_n), .pulse_enable_o(pulse_en));
  apb_host_model host (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  // ==========
  // Shared tasks.
  task automatic chk(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, output word_t r);
    logic e;
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wr(input logic [7:0] a, input word_t d);
    word_t r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input word_t exp);
    word_t r;
    rd(a, r);
    chk(r, exp);
  endtask
  // Waits out a pending post-processing run, then looks for growth over three DSP cycles.
  task automatic grow(input logic [7:0] a, input logic e);
    word_t x, y;
    repeat (60) @(posedge clk_i);
    rd(a, x);
    repeat (150) @(posedge clk_i);
    rd(a, y);
    chk({31'h0, y != x}, {31'h0, e});
  endtask
  task automatic zseq(input int p1, input int p2);
    int p[4];
    p = '{0, p1, p2, 0};
    foreach (p[k]) begin
      @(posedge clk_i);
      zc[p[k]] <= 1'b1;
      @(posedge clk_i);
      zc <= 3'h0;
      repeat (4) @(posedge clk_i);
    end
  endtask
  task automatic final_report;
    $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // Scenarios.
  task automatic t_reset;
    word_t r;
    logic e;
    chk({31'h0, pulse_en}, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    rdc(`OFF_NS, 32'h3E8);
    rdc(`OFF_CYC, 32'h10);
    rdc(`OFF_ACCDLY, 32'h5);
    rdc(`OFF_PH_HI, 32'h7FFF0000);
    host.xfer(1'b0, 8'hFC, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_delay;
    int n;
    wr(`OFF_ACCDLY, 32'h3);
    wr(`OFF_NS, 32'h4);
    n = 0;
    while (pulse_en !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, n >= 64}, 32'h1);
    rdc(`OFF_ACCDLY, 32'h0);
    rdc(`OFF_ACC0, 32'h0);
    grow(`OFF_ACC0, 1'b1);
    grow(8'h50, 1'b1);
    rdc(`OFF_FREQ, 32'h00BEBC20);
    $display("test delay done");
  endtask
  task automatic t_sign;
    wr(`OFF_CTRL, 32'h1);
    grow(8'h44, 1'b0);
    grow(8'h48, 1'b1);
    sq <= -16'sh4000;
    grow(8'h48, 1'b0);
    grow(8'h4C, 1'b1);
    si <= -16'sh4000;
    grow(8'h44, 1'b1);
    si <= 16'sh4000;
    sq <= 16'sh4000;
    $display("test sign done");
  endtask
  task automatic t_wiring;
    logic [3:0] neg = 4'b0110;
    for (int m = 0; m < 4; m++) begin
      wr(`OFF_CTRL, 32'h1 | (32'(m) << 1));
      grow(8'h58, neg[m]);
    end
    wr(`OFF_CTRL, 32'h1);
    $display("test wiring done");
  endtask
  task automatic t_offset;
    wr(`OFF_PH_HI, 32'h0);
    grow(`OFF_ACC0, 1'b0);
    wr(`OFF_THR_HI, 32'h200);
    wr(`OFF_THR_LO, 32'h80);
    grow(`OFF_ACC0, 1'b1);
    wr(`OFF_PH_MID, 32'h0);
    irms <= 16'h0040;
    grow(`OFF_ACC0, 1'b1);
    irms <= 16'h0100;
    grow(`OFF_ACC0, 1'b0);
    wr(`OFF_PH_MID, 32'h7FFF0000);
    $display("test offset done");
  endtask
  task automatic t_creep;
    wr(`OFF_CREEP, 32'h101);
    grow(`OFF_ACC0, 1'b0);
    wr(`OFF_CREEP, 32'h100);
    grow(`OFF_ACC0, 1'b1);
    wr(`OFF_OVF, 32'h0);
    rdc(`OFF_OVF, 32'h0);
    $display("test creep done");
  endtask
  task automatic t_missing_crossing_irq_bit;
    word_t r;
    wr(`OFF_CTRL, 32'h19);
    wr(`OFF_NZX, 32'h3);
    wr(`OFF_STAT, 32'h0);
    repeat (100) @(posedge clk_i);
    rd(`OFF_STAT, r);
    chk(r & 32'hF, 32'hF);
    chk({31'h0, irq_n}, 32'h0);
    wr(`OFF_NZX, 32'h0);
    wr(`OFF_STAT, 32'h0);
    repeat (3) @(posedge clk_i);
    rd(`OFF_STAT, r);
    chk(r & 32'hF, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    $display("test crossing done");
  endtask
  task automatic t_order;
    word_t r;
    zseq(2, 1);
    rd(`OFF_STAT, r);
    chk((r >> 4) & 32'h1, 32'h1);
    zseq(1, 2);
    rd(`OFF_STAT, r);
    chk((r >> 4) & 32'h1, 32'h0);
    $display("test order done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_delay();
    t_sign();
    t_wiring();
    t_offset();
    t_creep();
    t_missing_crossing_irq_bit();
    t_order();
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule

// >>> include/energy_params.svh
// Purpose: Offsets, reset values and scaling constants of the energy accumulator.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef ENERGY_PARAMS_SVH
`define ENERGY_PARAMS_SVH
`define OFF_CTRL 8'h00
`define OFF_NS 8'h04
`define OFF_CYC 8'h08
`define OFF_THR_HI 8'h0C
`define OFF_THR_LO 8'h10
`define OFF_PH_HI 8'h14
`define OFF_PH_MID 8'h18
`define OFF_PH_LO 8'h1C
`define OFF_NZX 8'h20
`define OFF_ACCDLY 8'h24
`define OFF_CREEP 8'h28
`define OFF_STAT 8'h2C
`define OFF_OVF 8'h30
`define OFF_FREQ 8'h34
`define OFF_ANG_AB 8'h38
`define OFF_ANG_AC 8'h3C
`define OFF_ACC0 8'h40
`define OFF_ACCN 8'h78
`define CYC_RST 8'h10
`define ACCDLY_RST 8'h05
`define NS_RST 16'h03E8
`define NZX_RST 16'h0100
`define OFFS_RST 32'h7FFF0000
`define FRAME_US 64'd320
`define MHZ_US 64'd1000000000
`define DEG_FULL 64'd36000
`define FRAC_SH 15
`define E_SH 16
`define ACC_PER_PH 4'h5
`endif

// >>> include/energy_pkg.sv
// Purpose: Types shared by the energy accumulator.
// Assumes: Nothing.
// Notes: Constants live in energy_params.svh.
package energy_pkg;
  typedef enum logic [2:0] {PP_IDLE, PP_CORR, PP_APP, PP_ACC, PP_FREQ} post_state_e;
  typedef logic [31:0] word_t;
endpackage

// >>> rtl/polyphase_energy_accumulator.sv
// Purpose: Per-DSP-cycle energy accumulation, line frequency, angles and crossing watch.
// Assumes: Samples, crossing pulses and RMS values come from logic on clk_i.
// Notes: APB slave, one wait state per access.
// Behaviour
// - Rotate energy by selected phase offset.
// - Offset chosen by RMS current against thresholds.
// - Method bit selects apparent and reactive formulas.
// - Line frequency from frames, frame time, cycles.
// - Angles from crossing counts, never negative.
// - Reactive energy split by sign, one update.
// - Real energy split by sign.
// - One apparent accumulator per phase.
// - Accumulator overflow sets its status bit.
// - Missing crossing timeout sets phase flag.
// - Masked flag sets summary; enabled drives irq low.
// - Master clears flags and summary by zero.
// - Order bit: ABC clears, ACB sets.
// - Frame count past limit saves, clears, triggers.
// - Accumulation continues during post-processing.
// - Phase B product chosen by wiring mode.
// - Nonzero delay blocks accumulation, decrements per DSP cycle.
// - Pulses suppressed while delay nonzero; resets five.
// - Below creep threshold phase does not accumulate.
// - Line cycles per DSP cycle reset sixteen.
`include "energy_params.svh"
`timescale 1ns/1ps
module polyphase_energy_accumulator import energy_pkg::*; (
  input wire logic clk_i, // 200 MHz clock
  input wire logic srst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic frame_tick_i, // One pulse per converter frame
  input wire logic signed [15:0] v_a_i, // Phase A voltage sample
  input wire logic signed [15:0] v_b_i, // Phase B voltage sample
  input wire logic signed [15:0] v_c_i, // Phase C voltage sample
  input wire logic signed [15:0] i_a_i, // Phase A current sample
  input wire logic signed [15:0] i_b_i, // Phase B current sample
  input wire logic signed [15:0] i_c_i, // Phase C current sample
  input wire logic signed [15:0] q_a_i, // Phase A quadrature current
  input wire logic signed [15:0] q_b_i, // Phase B quadrature current
  input wire logic signed [15:0] q_c_i, // Phase C quadrature current
  input wire logic zc_a_i, // Phase A rising crossing pulse
  input wire logic zc_b_i, // Phase B rising crossing pulse
  input wire logic zc_c_i, // Phase C rising crossing pulse
  input wire logic [15:0] irms_a_i, // Phase A raw RMS current
  input wire logic [15:0] irms_b_i, // Phase B raw RMS current
  input wire logic [15:0] irms_c_i, // Phase C raw RMS current
  input wire logic [15:0] vrms_a_i, // Phase A raw RMS voltage
  input wire logic [15:0] vrms_b_i, // Phase B raw RMS voltage
  input wire logic [15:0] vrms_c_i, // Phase C raw RMS voltage
  output logic irq_n_o, // Interrupt request, active low
  output logic pulse_enable_o // Meter pulses allowed
);
  // ==========================================================
  // Registers and decode
  logic [4:0] ctrl_reg;
  logic [15:0] ns_reg, thr_hi_reg, thr_lo_reg, nzx_reg;
  logic [7:0] cyc_reg, delay_reg;
  logic [31:0] off_hi_reg, off_mid_reg, off_lo_reg;
  logic [16:0] creep_reg;
  logic [2:0] flag_reg;
  logic irq_bit_reg, order_reg, overrun_reg, armed_reg, acc_en_reg;
  logic [14:0] ovf_reg, ovf_set;
  logic [31:0] acc_reg [0:14];
  logic [31:0] freq_reg, ang_ab_reg, ang_ac_reg, rd_data;
  logic hit, wr_en, trig;
  logic [15:0] frame_cnt_reg, since_a_reg, cnt_ab_reg, cnt_ac_reg;
  logic [15:0] nzx_cnt_reg [0:2];
  logic [2:0] zc, flag_set;
  post_state_e state_reg;
  logic [1:0] ph_reg;
  logic [3:0] base;
  always_comb begin
    hit = 1'b1;
    rd_data = 32'h0;
    if (paddr_i == `OFF_CTRL) rd_data = {27'h0, ctrl_reg};
    else if (paddr_i == `OFF_NS) rd_data = {16'h0, ns_reg};
    else if (paddr_i == `OFF_CYC) rd_data = {24'h0, cyc_reg};
    else if (paddr_i == `OFF_THR_HI) rd_data = {16'h0, thr_hi_reg};
    else if (paddr_i == `OFF_THR_LO) rd_data = {16'h0, thr_lo_reg};
    else if (paddr_i == `OFF_PH_HI) rd_data = off_hi_reg;
    else if (paddr_i == `OFF_PH_MID) rd_data = off_mid_reg;
    else if (paddr_i == `OFF_PH_LO) rd_data = off_lo_reg;
    else if (paddr_i == `OFF_NZX) rd_data = {16'h0, nzx_reg};
    else if (paddr_i == `OFF_ACCDLY) rd_data = {24'h0, delay_reg};
    else if (paddr_i == `OFF_CREEP) rd_data = {15'h0, creep_reg};
    else if (paddr_i == `OFF_STAT) rd_data = {26'h0, overrun_reg, order_reg, irq_bit_reg, flag_reg};
    else if (paddr_i == `OFF_OVF) rd_data = {17'h0, ovf_reg};
    else if (paddr_i == `OFF_FREQ) rd_data = freq_reg;
    else if (paddr_i == `OFF_ANG_AB) rd_data = ang_ab_reg;
    else if (paddr_i == `OFF_ANG_AC) rd_data = ang_ac_reg;
    else if (paddr_i >= `OFF_ACC0 && paddr_i <= `OFF_ACCN && paddr_i[1:0] == 2'h0)
      rd_data = acc_reg[4'((paddr_i - `OFF_ACC0) >> 2)];
    else hit = 1'b0;
  end
  assign wr_en = ce_i && psel_i && penable_i && pready_o && pwrite_i && hit;
  // APB answers one cycle after the access phase opens.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= psel_i && penable_i && !pready_o;
      prdata_o <= (psel_i && penable_i && !pready_o && !pwrite_i) ? rd_data : 32'h0;
      pslverr_o <= psel_i && penable_i && !pready_o && !hit;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_reg <= 5'h0;
      ns_reg <= `NS_RST;
      cyc_reg <= `CYC_RST;
      thr_hi_reg <= 16'h0;
      thr_lo_reg <= 16'h0;
      off_hi_reg <= `OFFS_RST;
      off_mid_reg <= `OFFS_RST;
      off_lo_reg <= `OFFS_RST;
      nzx_reg <= `NZX_RST;
      creep_reg <= 17'h0;
    end else if (wr_en) begin
      if (paddr_i == `OFF_CTRL) ctrl_reg <= pwdata_i[4:0];
      else if (paddr_i == `OFF_NS) ns_reg <= pwdata_i[15:0];
      else if (paddr_i == `OFF_CYC) cyc_reg <= pwdata_i[7:0];
      else if (paddr_i == `OFF_THR_HI) thr_hi_reg <= pwdata_i[15:0];
      else if (paddr_i == `OFF_THR_LO) thr_lo_reg <= pwdata_i[15:0];
      else if (paddr_i == `OFF_PH_HI) off_hi_reg <= pwdata_i;
      else if (paddr_i == `OFF_PH_MID) off_mid_reg <= pwdata_i;
      else if (paddr_i == `OFF_PH_LO) off_lo_reg <= pwdata_i;
      else if (paddr_i == `OFF_NZX) nzx_reg <= pwdata_i[15:0];
      else if (paddr_i == `OFF_CREEP) creep_reg <= pwdata_i[16:0];
    end
  end
  // ==========================================================
  // Frame accumulation
  logic signed [17:0] vsel;
  logic signed [47:0] prod_p [0:2], prod_q [0:2];
  logic signed [47:0] raw_p_reg [0:2], raw_q_reg [0:2], sav_p_reg [0:2], sav_q_reg [0:2];
  always_comb begin
    case (ctrl_reg[2:1])
      2'h0: vsel = 18'(v_b_i);
      2'h1: vsel = -18'(v_c_i);
      2'h2: vsel = -(18'(v_a_i) + 18'(v_c_i));
      default: vsel = -(18'(v_a_i) - 18'(v_c_i));
    endcase
    // Operands are widened first so the product is not cut to the operand width.
    prod_p[0] = 48'(v_a_i) * 48'(i_a_i);
    prod_q[0] = 48'(v_a_i) * 48'(q_a_i);
    prod_p[1] = 48'(vsel) * 48'(i_b_i);
    prod_q[1] = 48'(vsel) * 48'(q_b_i);
    prod_p[2] = 48'(v_c_i) * 48'(i_c_i);
    prod_q[2] = 48'(v_c_i) * 48'(q_c_i);
  end
  assign trig = ce_i && frame_tick_i && (frame_cnt_reg > ns_reg);
  always_ff @(posedge clk_i) begin
    if (srst_i) frame_cnt_reg <= 16'h0;
    else if (ce_i && frame_tick_i) frame_cnt_reg <= trig ? 16'h1 : frame_cnt_reg + 16'h1;
  end
  // Raw sums keep running while the saved copy is post-processed.
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (srst_i) begin
        raw_p_reg[k] <= 48'h0;
        raw_q_reg[k] <= 48'h0;
        sav_p_reg[k] <= 48'h0;
        sav_q_reg[k] <= 48'h0;
      end else if (trig) begin
        sav_p_reg[k] <= raw_p_reg[k];
        sav_q_reg[k] <= raw_q_reg[k];
        raw_p_reg[k] <= prod_p[k];
        raw_q_reg[k] <= prod_q[k];
      end else if (ce_i && frame_tick_i) begin
        raw_p_reg[k] <= raw_p_reg[k] + prod_p[k];
        raw_q_reg[k] <= raw_q_reg[k] + prod_q[k];
      end
    end
  end
  // ==========================================================
  // Post-processing
  function automatic logic [31:0] isqrt(input logic [63:0] x);
    logic [31:0] r;
    logic [63:0] t;
    r = 32'h0;
    for (int b = 31; b >= 0; b--) begin
      t = {32'h0, r | (32'h1 << b)};
      if (t * t <= x) r = r | (32'h1 << b);
    end
    return r;
  endfunction
  logic [15:0] irms, vrms;
  logic [31:0] off_sel;
  logic signed [31:0] ep, eq, p_w_reg, q_w_reg, p_abs, q_abs;
  logic signed [15:0] off_cos, off_sin;
  logic [31:0] s_w_reg, qmag;
  logic [63:0] p_sq, q_sq, s_sq;
  logic [32:0] sum_p, sum_q, sum_s;
  logic [3:0] pidx, qidx, sidx;
  logic creep, do_acc;
  always_comb begin
    irms = (ph_reg == 2'h0) ? irms_a_i : (ph_reg == 2'h1) ? irms_b_i : irms_c_i;
    vrms = (ph_reg == 2'h0) ? vrms_a_i : (ph_reg == 2'h1) ? vrms_b_i : vrms_c_i;
    if (irms >= thr_hi_reg) off_sel = off_hi_reg;
    else if (irms >= thr_lo_reg) off_sel = off_mid_reg;
    else off_sel = off_lo_reg;
    off_cos = off_sel[31:16];
    off_sin = off_sel[15:0];
    ep = 32'(sav_p_reg[ph_reg] >>> `E_SH);
    eq = 32'(sav_q_reg[ph_reg] >>> `E_SH);
    p_sq = 64'(p_w_reg) * 64'(p_w_reg);
    q_sq = 64'(q_w_reg) * 64'(q_w_reg);
    s_sq = {32'h0, s_w_reg} * {32'h0, s_w_reg};
    qmag = isqrt((s_sq > p_sq) ? s_sq - p_sq : 64'h0);
    base = 4'(ph_reg) * `ACC_PER_PH;
    p_abs = p_w_reg[31] ? -p_w_reg : p_w_reg;
    q_abs = q_w_reg[31] ? -q_w_reg : q_w_reg;
    pidx = base + {3'h0, p_w_reg[31]};
    qidx = base + 4'h2 + {3'h0, q_w_reg[31]};
    sidx = base + 4'h4;
    sum_p = {1'b0, acc_reg[pidx]} + {1'b0, p_abs};
    sum_q = {1'b0, acc_reg[qidx]} + {1'b0, q_abs};
    sum_s = {1'b0, acc_reg[sidx]} + {1'b0, s_w_reg};
    creep = (creep_reg != 17'h0) && ({1'b0, irms} < creep_reg);
    do_acc = ce_i && state_reg == PP_ACC && acc_en_reg && !creep;
    ovf_set = 15'h0;
    if (do_acc) ovf_set = (15'(sum_p[32]) << pidx) | (15'(sum_q[32]) << qidx) | (15'(sum_s[32]) << sidx);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= PP_IDLE;
      ph_reg <= 2'h0;
      p_w_reg <= 32'h0;
      q_w_reg <= 32'h0;
      s_w_reg <= 32'h0;
      freq_reg <= 32'h0;
      ang_ab_reg <= 32'h0;
      ang_ac_reg <= 32'h0;
    end else if (trig) begin
      state_reg <= PP_CORR;
      ph_reg <= 2'h0;
    end else if (ce_i) begin
      case (state_reg)
        PP_CORR: begin
          p_w_reg <= 32'((48'(ep) * 48'(off_cos) - 48'(eq) * 48'(off_sin)) >>> `FRAC_SH);
          q_w_reg <= 32'((48'(eq) * 48'(off_cos) + 48'(ep) * 48'(off_sin)) >>> `FRAC_SH);
          state_reg <= PP_APP;
        end
        PP_APP: begin
          if (ctrl_reg[0]) s_w_reg <= isqrt(p_sq + q_sq);
          else begin
            s_w_reg <= vrms * irms;
            q_w_reg <= q_w_reg[31] ? -qmag : qmag;
          end
          state_reg <= PP_ACC;
        end
        PP_ACC: begin
          ph_reg <= ph_reg + 2'h1;
          state_reg <= (ph_reg == 2'h2) ? PP_FREQ : PP_CORR;
        end
        PP_FREQ: begin
          if (ns_reg != 16'h0) begin
            freq_reg <= 32'(64'(cyc_reg) * `MHZ_US / (64'(ns_reg) * `FRAME_US));
            ang_ab_reg <= 32'((64'(cnt_ab_reg) * `DEG_FULL * 64'(cyc_reg) / 64'(ns_reg)) % `DEG_FULL);
            ang_ac_reg <= 32'((64'(cnt_ac_reg) * `DEG_FULL * 64'(cyc_reg) / 64'(ns_reg)) % `DEG_FULL);
          end
          state_reg <= PP_IDLE;
        end
        default: state_reg <= PP_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int k = 0; k < 15; k++) acc_reg[k] <= 32'h0;
    end else if (do_acc) begin
      acc_reg[pidx] <= sum_p[31:0];
      acc_reg[qidx] <= sum_q[31:0];
      acc_reg[sidx] <= sum_s[31:0];
    end
  end
  // A set in the same cycle as a clearing write wins.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ovf_reg <= 15'h0;
      overrun_reg <= 1'b0;
    end else if (ce_i) begin
      ovf_reg <= ((wr_en && paddr_i == `OFF_OVF) ? ovf_reg & pwdata_i[14:0] : ovf_reg) | ovf_set;
      overrun_reg <= ((wr_en && paddr_i == `OFF_STAT) ? overrun_reg & pwdata_i[5] : overrun_reg)
                     | (trig && state_reg != PP_IDLE);
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      delay_reg <= `ACCDLY_RST;
      acc_en_reg <= 1'b0;
      pulse_enable_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_en && paddr_i == `OFF_ACCDLY) delay_reg <= pwdata_i[7:0];
      else if (trig && delay_reg != 8'h0) delay_reg <= delay_reg - 8'h1;
      if (trig) acc_en_reg <= (delay_reg == 8'h0);
      pulse_enable_o <= (delay_reg == 8'h0);
    end
  end
  // ==========================================================
  // Crossing watch and phase order
  assign zc = {zc_c_i, zc_b_i, zc_a_i};
  always_comb begin
    for (int k = 0; k < 3; k++)
      flag_set[k] = frame_tick_i && !zc[k] && nzx_reg != 16'h0 && nzx_cnt_reg[k] >= nzx_reg;
  end
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (srst_i) nzx_cnt_reg[k] <= 16'h0;
      else if (ce_i && zc[k]) nzx_cnt_reg[k] <= 16'h0;
      else if (ce_i && frame_tick_i && nzx_cnt_reg[k] != 16'hFFFF) nzx_cnt_reg[k] <= nzx_cnt_reg[k] + 16'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_reg <= 3'h0;
      irq_bit_reg <= 1'b0;
      irq_n_o <= 1'b1;
    end else if (ce_i) begin
      flag_reg <= ((wr_en && paddr_i == `OFF_STAT) ? flag_reg & pwdata_i[2:0] : flag_reg) | flag_set;
      irq_bit_reg <= ((wr_en && paddr_i == `OFF_STAT) ? irq_bit_reg & pwdata_i[3] : irq_bit_reg)
                     | (ctrl_reg[3] && |flag_set);
      irq_n_o <= !(irq_bit_reg && ctrl_reg[4]);
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      armed_reg <= 1'b0;
      order_reg <= 1'b0;
      since_a_reg <= 16'h0;
      cnt_ab_reg <= 16'h0;
      cnt_ac_reg <= 16'h0;
    end else if (ce_i) begin
      if (zc_a_i) begin
        armed_reg <= 1'b1;
        since_a_reg <= 16'h0;
      end else begin
        if (frame_tick_i && since_a_reg != 16'hFFFF) since_a_reg <= since_a_reg + 16'h1;
        if (zc_b_i && armed_reg) begin
          order_reg <= 1'b0;
          armed_reg <= 1'b0;
        end else if (zc_c_i && armed_reg) begin
          order_reg <= 1'b1;
          armed_reg <= 1'b0;
        end
      end
      if (zc_b_i) cnt_ab_reg <= since_a_reg;
      if (zc_c_i) cnt_ac_reg <= since_a_reg;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_off_sel;
    (state_reg == PP_CORR && irms >= thr_hi_reg) |-> off_sel == off_hi_reg;
  endproperty
  a_off_sel: assert property (p_off_sel) else $error("high offset not chosen");
  property p_one_sign;
    do_acc |=> !(acc_reg[$past(base) + 4'h2] != $past(acc_reg[base + 4'h2])
                 && acc_reg[$past(base) + 4'h3] != $past(acc_reg[base + 4'h3]));
  endproperty
  a_one_sign: assert property (p_one_sign) else $error("both reactive accumulators moved");
  property p_ovf;
    (do_acc && sum_s[32]) |=> ovf_reg[$past(sidx)];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow bit not set");
  property p_nzx;
    (ce_i && flag_set[0]) |=> flag_reg[0];
  endproperty
  a_nzx: assert property (p_nzx) else $error("missing crossing flag not set");
  property p_irq;
    (ce_i && irq_bit_reg && ctrl_reg[4]) |=> !irq_n_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not driven low");
  property p_order;
    (ce_i && armed_reg && zc_c_i && !zc_b_i && !zc_a_i) |=> order_reg;
  endproperty
  a_order: assert property (p_order) else $error("order bit not set for ACB");
  property p_trig;
    trig |=> frame_cnt_reg == 16'h1 && state_reg == PP_CORR ##3 state_reg == PP_CORR;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger did not restart processing");
  property p_delay;
    (trig && delay_reg != 8'h0 && !(wr_en && paddr_i == `OFF_ACCDLY)) |=> delay_reg == $past(delay_reg) - 8'h1 && !acc_en_reg;
  endproperty
  a_delay: assert property (p_delay) else $error("delay not decremented");
  property p_pulse;
    (ce_i && delay_reg != 8'h0) |=> !pulse_enable_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulses not suppressed");
  property p_creep;
    (ce_i && state_reg == PP_ACC && creep) |=> acc_reg[$past(sidx)] == $past(acc_reg[sidx]);
  endproperty
  a_creep: assert property (p_creep) else $error("creep phase accumulated");
  c_acc: cover property (do_acc ##1 state_reg == PP_CORR);
  c_irq: cover property (!irq_n_o);
  c_overrun: cover property (trig && state_reg != PP_IDLE);
endmodule
